// ==== design/evrt_channel.sv ====
// evrt_channel: one channel of the event_router, carrying events from a generator
// to up to four users (single pulses on sync and resync, the level on async), with flags and interrupt.
// assumes all inputs synchronous to clock except gen_level on the
// resynchronized path, which is brought in through two flip-flops.
//
// Operation
// - sync path raises interrupts, updates status
// - resync path resynchronizes generator inside channel
// - resync path raises interrupts, updates status
// - edge_select picks rising, falling or both
// - sync path delivers within one cycle
// - resync path delivers within three cycles
// - user sees event within three cycles
// - overrun when user not ready or busy
// - overrun never set on async path
// - event_detected_flag set on each sync or resync path event
// - debugger writes bypass access_guard protection
//
// The address-and-strobe port and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
module evrt_channel (
    input  wire logic                              clock,
    input  wire logic                              resetn,
    input  wire evrt_pkg::evrt_req_type            req,
    output logic [evrt_pkg::EVRT_DW-1:0]           rdata,
    input  wire logic                              guard_protect,
    input  wire logic                              debug_access,
    input  wire logic                              gen_level,
    input  wire logic [evrt_pkg::EVRT_USERS-1:0]   user_ready,
    input  wire logic [evrt_pkg::EVRT_USERS-1:0]   user_done,
    output logic [evrt_pkg::EVRT_USERS-1:0]        user_event,
    output logic                                   irq
);
    import evrt_pkg::*;

    // decoded configuration fields
    function automatic evrt_path_type cfg_path(input logic [31:0] c);
        cfg_path = evrt_path_type'(c[CFG_PATH_LSB +: 2]);
    endfunction

    function automatic evrt_edge_type cfg_edge(input logic [31:0] c);
        cfg_edge = evrt_edge_type'(c[CFG_EDGE_LSB +: 2]);
    endfunction

    // edge qualifier shared by both clocked paths
    function automatic logic edge_hit(input evrt_edge_type e, input logic cur,
                                      input logic prv);
        case (e)
            EDGE_RISING:  edge_hit = cur & ~prv;
            EDGE_FALLING: edge_hit = ~cur & prv;
            EDGE_BOTH:    edge_hit = cur ^ prv;
            default:      edge_hit = 1'b0;
        endcase
    endfunction

    // register state
    logic [31:0]           config_q, config_d;     // channel_config_reg_n
    logic [1:0]            mask_q, mask_d;         // interrupt enables
    logic [1:0]            flags_q, flags_d;       // channel_flag_reg_n
    logic [31:0]           rdata_q, rdata_d;       // read data, one cycle later
    logic                  irq_q, irq_d;
    // event path state
    logic                  sync1_q, sync1_d;       // resync first stage
    logic                  sync2_q, sync2_d;       // resync second stage
    logic                  prev_s_q, prev_s_d;     // last sampled level, sync
    logic                  prev_r_q, prev_r_d;     // last level, resync
    logic [EVRT_USERS-1:0] uev_q, uev_d;           // event pulse to users
    logic [EVRT_USERS-1:0] pend_q, pend_d;         // users still handling

    // combinational helpers
    evrt_path_type         path;
    evrt_edge_type         edge_sel;
    logic [EVRT_USERS-1:0] users;
    logic                  ev_sync, ev_resync, ev_new, overrun;
    logic                  wr_ok;
    logic [31:0]           state_word;

    // field decode and event detection
    always_comb begin
        path       = cfg_path(config_q);
        edge_sel   = cfg_edge(config_q);
        users      = config_q[CFG_USER_LSB +: EVRT_USERS];
        // sync path compares the live level with last cycle's sample
        ev_sync    = edge_hit(edge_sel, gen_level, prev_s_q);
        // resync path only looks at the second stage
        ev_resync  = edge_hit(edge_sel, sync2_q, prev_r_q);
        case (path)
            PATH_SYNC:   ev_new = ev_sync;
            PATH_RESYNC: ev_new = ev_resync;
            default:     ev_new = 1'b0;            // async carries no flags
        endcase
        // a connected user not ready, or still busy with the last one
        overrun    = ev_new & (|(users & (~user_ready | pend_q)));
        // debugger writes are never blocked by the guard
        wr_ok      = req.wr & (~guard_protect | debug_access);
        state_word = '0;
        state_word[ST_BUSY]                  = |pend_q;
        state_word[ST_RDY]                   = &(~users | user_ready);
        state_word[ST_PEND_LSB +: EVRT_USERS] = pend_q;
        state_word[ST_URDY_LSB +: EVRT_USERS] = user_ready;
    end

    // event path next state
    always_comb begin
        sync1_d  = gen_level;
        sync2_d  = sync1_q;
        prev_s_d = gen_level;
        prev_r_d = sync2_q;
        case (path)
            // one-cycle delivery from the input edge
            PATH_SYNC:   uev_d = ev_sync ? users : '0;
            // two sync stages plus the output flop: three cycles
            PATH_RESYNC: uev_d = ev_resync ? users : '0;
            // async: level passed on through the output flop, one cycle later
            PATH_ASYNC:  uev_d = gen_level ? users : '0;
            default:     uev_d = '0;
        endcase
        // pending tracks who has not handled the event; a new delivery
        // in the same cycle as a done re-arms the user
        pend_d = (pend_q & ~user_done) | (ev_new ? users : '0);
    end

    // event path registers
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            sync1_q  <= 1'b0;
            sync2_q  <= 1'b0;
            prev_s_q <= 1'b0;
            prev_r_q <= 1'b0;
            uev_q    <= '0;
            pend_q   <= '0;
        end else begin
            sync1_q  <= sync1_d;
            sync2_q  <= sync2_d;
            prev_s_q <= prev_s_d;
            prev_r_q <= prev_r_d;
            uev_q    <= uev_d;
            pend_q   <= pend_d;
        end
    end

    // register file next state
    always_comb begin
        config_d = config_q;
        mask_d   = mask_q;
        flags_d  = flags_q;
        rdata_d  = '0;                             // unmapped reads give zero
        irq_d    = 1'b0;
        if (wr_ok) begin
            case (req.addr)
                OFS_CONFIG: config_d = req.wdata;
                OFS_MASK:   mask_d   = req.wdata[1:0];
                // write one clears a flag
                OFS_FLAG:   flags_d  = flags_q & ~req.wdata[1:0];
                default:    ;
            endcase
        end
        if (req.rd) begin
            case (req.addr)
                OFS_CONFIG: rdata_d = config_q;
                OFS_MASK:   rdata_d = {30'h0000_0000, mask_q};
                OFS_FLAG: begin
                    rdata_d = {30'h0000_0000, flags_q};
                    flags_d = 2'h0;                // reading clears the flags
                end
                OFS_STATE:  rdata_d = state_word;  // status kept live
                default:    rdata_d = '0;
            endcase
        end
        // hardware sets win over a read or write-one clear in the same cycle
        if (ev_new) begin
            flags_d[FLG_EVD] = 1'b1;
        end
        if (overrun) begin
            flags_d[FLG_OVR] = 1'b1;
        end
        // async path always shows a clear overrun flag
        if (cfg_path(config_d) == PATH_ASYNC) begin
            flags_d[FLG_OVR] = 1'b0;
        end
        // level interrupt while any enabled flag stands
        irq_d = |(flags_d & mask_d);
    end

    // register file registers
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            config_q <= RST_CONFIG;
            mask_q   <= RST_MASK;
            flags_q  <= RST_FLAGS;
            rdata_q  <= '0;
            irq_q    <= 1'b0;
        end else begin
            config_q <= config_d;
            mask_q   <= mask_d;
            flags_q  <= flags_d;
            rdata_q  <= rdata_d;
            irq_q    <= irq_d;
        end
    end

    // outputs straight from flops
    assign rdata      = rdata_q;
    assign user_event = uev_q;
    assign irq        = irq_q;

    // checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);

    sequence s_rise_sync;
        path == PATH_SYNC && edge_sel == EDGE_RISING && gen_level && !prev_s_q
            && users != '0;
    endsequence

    sequence s_rise_resync;
        path == PATH_RESYNC && edge_sel == EDGE_RISING && !sync1_q
            && gen_level && users != '0;
    endsequence

    a_sync_latency: assert property (
        s_rise_sync |=> user_event == $past(users)
    ) else $error("sync event not delivered in one cycle");

    a_resync_latency: assert property (
        s_rise_resync ##1 (gen_level && $stable(config_q))
            ##1 $stable(config_q) |=> user_event != '0
    ) else $error("resync event not delivered in three cycles");

    a_async_no_ovr: assert property (
        path == PATH_ASYNC |=> !flags_q[FLG_OVR]
    ) else $error("overrun flag set on async path");

    a_evd_set: assert property (
        ev_new |=> flags_q[FLG_EVD]
    ) else $error("event detected flag not set");

    a_ovr_set: assert property (
        (ev_new && (users & ~user_ready) != '0 && path != PATH_ASYNC)
            |=> flags_q[FLG_OVR]
    ) else $error("overrun flag not set for busy user");

    a_irq_level: assert property (
        irq == |($past(flags_d) & $past(mask_d))
    ) else $error("irq does not follow enabled flags");

    a_guard_block: assert property (
        (req.wr && req.addr == OFS_MASK && guard_protect && !debug_access)
            |=> $stable(mask_q)
    ) else $error("protected write changed mask");

    a_debug_pass: assert property (
        (req.wr && req.addr == OFS_MASK && debug_access)
            |=> mask_q == $past(req.wdata[1:0])
    ) else $error("debugger write blocked");

    a_edge_none: assert property (
        edge_sel == EDGE_NONE && path != PATH_ASYNC |-> !ev_new
    ) else $error("event without edge detection");

    // all enables clear: no flag may reach the interrupt pin
    a_irq_masked: assert property (
        mask_d == 2'h0 |=> !irq
    ) else $error("irq raised with all enables clear");

    // a flag read clears both flags unless hardware sets in that cycle
    a_flag_rd_clear: assert property (
        (req.rd && req.addr == OFS_FLAG && !ev_new) |=> flags_q == 2'h0
    ) else $error("flag read did not clear");

    // write one clears a flag; a zero bit leaves it alone
    a_w1c_clear: assert property (
        (wr_ok && req.addr == OFS_FLAG && !ev_new)
            |=> flags_q == ($past(flags_q) & ~$past(req.wdata[1:0]))
    ) else $error("write one did not clear flag");

    // every sync or resync delivery leaves its users pending until they report done
    a_pend_track: assert property (
        ev_new |=> (pend_q & $past(users)) == $past(users)
    ) else $error("delivered user not marked pending");

    // the level change that the second stage sees, two and three cycles back
    sequence s_level_step;
        $past(gen_level, 2) != $past(gen_level, 3);
    endsequence

    // a resync event needs the input to have crossed both stages
    a_resync_stages: assert property (
        (path == PATH_RESYNC && ev_resync) |-> s_level_step
    ) else $error("resync event without a two stage level change");

    // the status view carries the live per-user ready bits
    a_state_read: assert property (
        (req.rd && req.addr == OFS_STATE)
            |=> rdata[ST_URDY_LSB +: EVRT_USERS] == $past(user_ready)
    ) else $error("status read lost user ready bits");

    // read data stand for one cycle only; the port idles at zero
    a_rdata_idle: assert property (
        !req.rd |=> rdata == '0
    ) else $error("read data not zero without a read");

endmodule

// ==== inc/evrt_pkg.sv ====
// evrt_pkg: constants, enumerations and carriers of the event channel router.
// assumes a single 100 MHz clock and a plain strobe register port.
package evrt_pkg;

    // register port widths and user count
    localparam int          EVRT_AW       = 8;
    localparam int          EVRT_DW       = 32;
    localparam int          EVRT_USERS    = 4;

    // register offsets (byte addresses)
    localparam logic [7:0]  OFS_CONFIG    = 8'h00;  // channel_config_reg_n
    localparam logic [7:0]  OFS_MASK      = 8'h04;  // interrupt enable mask
    localparam logic [7:0]  OFS_FLAG      = 8'h08;  // channel_flag_reg_n
    localparam logic [7:0]  OFS_STATE     = 8'h0C;  // channel_state_reg

    // config field positions
    localparam int          CFG_PATH_LSB  = 0;      // two bits: path
    localparam int          CFG_EDGE_LSB  = 2;      // two bits: edge_select
    localparam int          CFG_USER_LSB  = 8;      // user connection mask

    // flag / mask bit positions
    localparam int          FLG_OVR       = 0;      // overrun_flag
    localparam int          FLG_EVD       = 1;      // event_detected_flag

    // state field positions
    localparam int          ST_BUSY       = 0;      // some user still handling
    localparam int          ST_RDY        = 1;      // all connected users ready
    localparam int          ST_PEND_LSB   = 8;      // per-user pending
    localparam int          ST_URDY_LSB   = 12;     // per-user ready

    // reset values
    localparam logic [31:0] RST_CONFIG    = 32'h0000_0000;
    localparam logic [1:0]  RST_FLAGS     = 2'h0;
    localparam logic [1:0]  RST_MASK      = 2'h0;

    // latency bounds in channel clock cycles
    localparam int          LAT_SYNC      = 1;
    localparam int          LAT_RESYNC    = 3;
    localparam int          LAT_USER      = 3;

    // path selection
    typedef enum logic [1:0] {
        PATH_SYNC   = 2'b00,
        PATH_RESYNC = 2'b01,
        PATH_ASYNC  = 2'b10
    } evrt_path_type;

    // edge_select encoding
    typedef enum logic [1:0] {
        EDGE_NONE    = 2'b00,
        EDGE_RISING  = 2'b01,
        EDGE_FALLING = 2'b10,
        EDGE_BOTH    = 2'b11
    } evrt_edge_type;

    // one register port request
    typedef struct packed {
        logic [EVRT_AW-1:0] addr;
        logic [EVRT_DW-1:0] wdata;
        logic               wr;
        logic               rd;
    } evrt_req_type;

endpackage

// ==== testbench/evrt_channel_tb.sv ====
// evrt_channel_tb: self-checking bench for one event router channel.
// assumes the user model answers events; registers via strobe port.
`timescale 1ns/10ps
module evrt_channel_tb;
    import evrt_pkg::*;
    logic                  clock;
    logic                  resetn;
    logic                  guard_protect;
    logic                  debug_access;
    logic                  gen_level;
    logic                  stall;
    logic                  irq;
    logic [EVRT_USERS-1:0] busy, user_ready, user_done, user_event, seen;
    logic [EVRT_DW-1:0]    rdata, val;
    evrt_req_type          req;
    int                    err_count = 0;
    int                    comparisons = 0;
    int                    cycles = 0;

    evrt_channel dut_u (
        .clock         (clock),
        .resetn        (resetn),
        .req           (req),
        .rdata         (rdata),
        .guard_protect (guard_protect),
        .debug_access  (debug_access),
        .gen_level     (gen_level),
        .user_ready    (user_ready),
        .user_done     (user_done),
        .user_event    (user_event),
        .irq           (irq)
    );
    evrt_user_model model_u (
        .clock      (clock),
        .resetn     (resetn),
        .user_event (user_event),
        .stall      (stall),
        .busy       (busy),
        .user_ready (user_ready),
        .user_done  (user_done)
    );

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    // hang guard: the whole run needs well under a thousand cycles
    always @(posedge clock) begin
        cycles++;
        if (cycles == 4000) begin
            err_count++;
            $display("mismatch timeout expected finish seen hang");
            end_sim();
        end
    end

    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            $display("mismatch %s expected %h seen %h", n, e, g);
            err_count++;
        end
    endtask

    // one-cycle write strobe, released at the edge that takes it
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clock);
        req.wr <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic reg_rd(input logic [7:0] a);
        @(posedge clock);
        req <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
        @(posedge clock);
        req.rd <= 1'b0;
        #1 val = rdata;
    endtask

    // move the generator, then gather user pulses over n cycles
    task automatic ev(input logic v, input int n);
        @(posedge clock);
        gen_level <= v;
        seen = '0;
        repeat (n) begin
            @(posedge clock);
            #1 seen |= user_event;
        end
    endtask

    task automatic t_reset();
        reg_rd(OFS_CONFIG);
        chk("config reset", RST_CONFIG, val);
        reg_rd(OFS_MASK);
        chk("mask reset", 32'h0000_0000, val);
        reg_rd(OFS_FLAG);
        chk("flag reset", 32'h0000_0000, val);
        reg_wr(8'h10, 32'hFFFF_FFFF);
        reg_rd(8'h10);
        chk("unmapped read", 32'h0000_0000, val);
        $display("done reset values");
    endtask

    // every edge_select code on the sync path, users 0 and 1
    task automatic t_edges();
        for (int e = 0; e < 4; e++) begin
            reg_wr(OFS_CONFIG, 32'h0000_0300 | (e << CFG_EDGE_LSB));
            ev(1'b1, 1);
            chk("rise event", e[0] ? 4'h3 : 4'h0, seen);
            ev(1'b0, 1);
            chk("fall event", e[1] ? 4'h3 : 4'h0, seen);
        end
        $display("done edge select");
    endtask

    task automatic t_resync();
        reg_rd(OFS_FLAG);
        reg_wr(OFS_CONFIG, 32'h0000_0F05);
        ev(1'b1, 3);
        chk("resync event", 32'h0000_000F, seen);
        ev(1'b0, 3);
        chk("resync no fall", 32'h0000_0000, seen);
        reg_rd(OFS_FLAG);
        chk("resync flags", 32'h0000_0002, val);
        $display("done resync path");
    endtask

    task automatic t_irq();
        reg_wr(OFS_CONFIG, 32'h0000_0105);
        reg_rd(OFS_FLAG);
        ev(1'b1, 1);
        ev(1'b0, 1);
        chk("masked irq", 1'b0, irq);
        reg_wr(OFS_MASK, 32'h0000_0002);
        @(posedge clock);
        #1 chk("irq raised", 1'b1, irq);
        reg_wr(OFS_FLAG, 32'h0000_0002);
        @(posedge clock);
        #1 chk("irq after clear", 1'b0, irq);
        reg_rd(OFS_FLAG);
        chk("flag w1c", 32'h0000_0000, val);
        $display("done interrupt");
    endtask

    // stalled user then a not-ready user both cause overrun
    task automatic t_ovr();
        reg_wr(OFS_MASK, 32'h0000_0001);
        stall <= 1'b1;
        ev(1'b1, 1);
        ev(1'b0, 1);
        ev(1'b1, 1);
        reg_rd(OFS_STATE);
        chk("state pending", 32'h0000_F103, val);
        chk("ovr irq", 1'b1, irq);
        reg_rd(OFS_FLAG);
        chk("ovr flags", 32'h0000_0003, val);
        reg_rd(OFS_FLAG);
        chk("read clears", 32'h0000_0000, val);
        stall <= 1'b0;
        busy  <= 4'h1;
        ev(1'b0, 3);
        ev(1'b1, 3);
        reg_rd(OFS_FLAG);
        chk("not ready ovr", 32'h0000_0003, val);
        busy <= 4'h0;
        reg_wr(OFS_MASK, 32'h0000_0000);
        $display("done overrun");
    endtask

    // raise an overrun on the resync path, then switch to async: it must hide
    task automatic t_async();
        busy <= 4'h1;
        ev(1'b0, 1);
        ev(1'b1, 3);
        busy <= 4'h0;
        reg_wr(OFS_CONFIG, 32'h0000_0106);
        reg_rd(OFS_FLAG);
        chk("async ovr hidden", 32'h0000_0002, val);
        stall <= 1'b1;
        ev(1'b0, 1);
        ev(1'b1, 1);
        chk("async follow", 32'h0000_0001, seen);
        ev(1'b0, 1);
        ev(1'b1, 1);
        reg_rd(OFS_FLAG);
        chk("async no ovr", 32'h0000_0000, val);
        stall <= 1'b0;
        $display("done async path");
    endtask

    task automatic t_guard();
        guard_protect <= 1'b1;
        reg_wr(OFS_MASK, 32'h0000_0003);
        reg_rd(OFS_MASK);
        chk("guarded write", 32'h0000_0000, val);
        debug_access <= 1'b1;
        reg_wr(OFS_MASK, 32'h0000_0003);
        reg_rd(OFS_MASK);
        chk("debug write", 32'h0000_0003, val);
        guard_protect <= 1'b0;
        debug_access  <= 1'b0;
        $display("done access guard");
    endtask

    initial begin
        req           = '0;
        resetn        = 1'b0;
        guard_protect = 1'b0;
        debug_access  = 1'b0;
        gen_level     = 1'b0;
        stall         = 1'b0;
        busy          = '0;
        repeat (4) @(posedge clock);
        resetn <= 1'b1;
        t_reset();
        t_edges();
        t_resync();
        t_irq();
        t_ovr();
        t_async();
        t_guard();
        end_sim();
    end
endmodule

// ==== testbench/evrt_user_model.sv ====
// evrt_user_model: behavioural event users on the far side of one channel.
// assumes events arrive as one-cycle pulses on the channel clock.
`timescale 1ns/10ps
module evrt_user_model (
    input  wire logic                            clock,
    input  wire logic                            resetn,
    input  wire logic [evrt_pkg::EVRT_USERS-1:0] user_event,
    input  wire logic                            stall,
    input  wire logic [evrt_pkg::EVRT_USERS-1:0] busy,
    output logic      [evrt_pkg::EVRT_USERS-1:0] user_ready,
    output logic      [evrt_pkg::EVRT_USERS-1:0] user_done
);
    import evrt_pkg::*;
    logic [EVRT_USERS-1:0] pend_q; // events taken, not yet handled
    logic [EVRT_USERS-1:0] pend_d;
    logic [EVRT_USERS-1:0] done_q; // handled pulse towards the channel
    logic [EVRT_USERS-1:0] done_d;
    // a busy user is simply not ready; the bench picks who
    assign user_ready = ~busy;
    assign user_done  = done_q;
    // handle one cycle after arrival, inside the latency budget
    // stall holds every event back so the channel sees a slow user
    always_comb begin
        done_d = stall ? '0 : pend_q;
        pend_d = (pend_q & ~done_d) | user_event;
    end
    // state registers
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            pend_q <= '0;
            done_q <= '0;
        end else begin
            pend_q <= pend_d;
            done_q <= done_d;
        end
    end
endmodule
